// ===== hw/baseline_instruction_execute.sv
`timescale 1ns/1ps
// Executes a subset of the 12-bit instruction set in two clocks per instruction cycle
module baseline_instruction_execute
  import exec_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Program memory
  output logic [PC_W-1:0] prog_addr,
  input wire logic [INSTR_W-1:0] instr_data,
  // Architectural state
  output core_view_t view,
  // One-clock pulse at the end of each instruction cycle
  output logic retire
);

  // Registered state and its next copy
  core_state_t state;
  core_state_t next_state;

  // File slot port signals
  logic wr_en;
  logic [SLOT_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [SLOT_W-1:0] rd_addr;
  logic [DATA_W-1:0] rd_data;

  // Decoded fields of the held instruction
  logic dest_slot; // 1 writes the slot back, 0 the accumulator
  logic [SLOT_W-1:0] slot; // Addressed file slot
  logic [DATA_W-1:0] literal; // Eight-bit immediate
  logic [DATA_W-1:0] result; // Value before it is routed
  logic result_zero; // Result is all zeros

  // One flag per supported opcode; none set means the word runs as a no-operation
  logic branch_word; // Absolute branch
  logic or_lit_word; // OR immediate into accumulator
  logic load_lit_word; // Load immediate into accumulator
  logic store_word; // Copy accumulator into slot
  logic option_load_word; // Copy accumulator into option register
  logic or_file_word; // OR accumulator with slot
  logic move_word; // Copy slot to destination
  logic inc_word; // Increment slot
  logic dec_skip_word; // Decrement slot, skip on zero
  logic inc_skip_word; // Increment slot, skip on zero
  logic slot_form; // Any form that computes from the slot
  logic zero_form; // Slot forms that update the zero flag
  logic skip_form; // Slot forms that may skip

  // Field extraction
  assign dest_slot = state.ir[DEST_BIT];
  assign slot = state.ir[SLOT_W-1:0];
  assign literal = state.ir[LIT_MSB:0];

  // Opcode decode; the patterns do not overlap, so no priority is implied
  assign branch_word = (state.ir & MASK_K9) == BRANCH_PAT;
  assign or_lit_word = (state.ir & MASK_K8) == OR_LIT_PAT;
  assign load_lit_word = (state.ir & MASK_K8) == LOAD_LIT_PAT;
  assign store_word = (state.ir & MASK_F) == STORE_ACC_PAT;
  assign option_load_word = state.ir == OPTION_WORD;
  assign or_file_word = (state.ir & MASK_DF) == OR_FILE_PAT;
  assign move_word = (state.ir & MASK_DF) == MOVE_FILE_PAT;
  assign inc_word = (state.ir & MASK_DF) == INC_FILE_PAT;
  assign dec_skip_word = (state.ir & MASK_DF) == DEC_SKIP_PAT;
  assign inc_skip_word = (state.ir & MASK_DF) == INC_SKIP_PAT;
  assign slot_form = or_file_word || move_word || inc_word || dec_skip_word || inc_skip_word;
  // Only the two skip forms leave the status alone
  assign zero_form = or_file_word || move_word || inc_word;
  // Skips are the only slot forms that may flush
  assign skip_form = dec_skip_word || inc_skip_word;

  // Slot storage; address is presented during fetch so data is ready for execute
  file_slots u_slots (
    .clock(clock),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  // Next-state logic: fetch latches the word, execute acts on it
  always_comb
  begin
    // Defaults: no write, no retire, state held
    next_state = state;
    next_state.retire = 1'b0;
    wr_en = 1'b0;
    wr_addr = slot;
    wr_data = 8'h00;
    rd_addr = instr_data[SLOT_W-1:0];
    result = 8'h00;
    result_zero = 1'b0;
    // Two clocks per instruction cycle: fetch, then execute
    unique case (state.phase)
      PH_FETCH:
      begin
        // A flushed fetch runs one no-operation cycle in place of the word
        next_state.ir = state.flush ? NOP_WORD : instr_data;
        next_state.flush = 1'b0;
        if (!state.flush)
        begin
          // Normal fetch steps past the word just taken
          next_state.pc = state.pc + 9'h001;
        end
        // Execute always follows fetch
        next_state.phase = PH_EXEC;
      end
      PH_EXEC:
      begin
        next_state.phase = PH_FETCH;
        // Retire pulses once per instruction cycle, flushed ones included
        next_state.retire = 1'b1;
        if (branch_word)
        begin
          // Counter has no bits above 8, so the page bits have nowhere to land
          next_state.pc = state.ir[BRANCH_ABSOLUTE_OP_K_MSB:0];
          // Counter is held on the flushed fetch, so the target word still runs afterwards
          next_state.flush = 1'b1;
        end
        else if (or_lit_word)
        begin
          // Immediate OR, zero flag follows the result
          result = state.view.acc | literal;
          result_zero = (result == 8'h00);
          next_state.view.acc = result;
          next_state.view.status[ZERO_BIT] = result_zero;
        end
        else if (load_lit_word)
        begin
          // Immediate load, status untouched
          next_state.view.acc = literal;
        end
        else if (store_word)
        begin
          // Accumulator into the slot, status untouched
          wr_en = 1'b1;
          wr_data = state.view.acc;
        end
        else if (option_load_word)
        begin
          // Accumulator into the option register
          next_state.view.option = state.view.acc;
        end
        else if (slot_form)
        begin
          // Arithmetic on the slot read during fetch
          if (or_file_word)
          begin
            result = state.view.acc | rd_data;
          end
          else if (move_word)
          begin
            result = rd_data;
          end
          else if (dec_skip_word)
          begin
            result = rd_data - 8'h01;
          end
          else
          begin
            // Plain increment and increment-skip share the adder
            result = rd_data + 8'h01;
          end
          // Zero test shared by the flag and the skip
          result_zero = (result == 8'h00);
          // Destination choice
          if (dest_slot)
          begin
            wr_en = 1'b1;
            wr_data = result;
          end
          else
          begin
            next_state.view.acc = result;
          end
          // Flag-affecting forms; move to its own slot still updates, so it tests
          if (zero_form)
          begin
            next_state.view.status[ZERO_BIT] = result_zero;
          end
          // A zero skip steps over the next word and runs a no-operation cycle in its place
          if (skip_form && result_zero)
          begin
            next_state.pc = state.pc + 9'h001;
            next_state.flush = 1'b1;
          end
        end
        else
        begin
          // No-operation and unsupported words change nothing
          next_state.flush = 1'b0;
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      state.phase <= PH_FETCH;
      state.pc <= PC_RESET;
      state.ir <= NOP_WORD;
      state.flush <= 1'b0;
      state.retire <= 1'b0;
      state.view.acc <= ACC_RESET;
      state.view.status <= STATUS_RESET;
      state.view.option <= OPTION_RESET;
    end
    else
    begin
      state <= next_state;
    end
  end

  // Outputs straight from flops
  assign prog_addr = state.pc;
  assign view = state.view;
  assign retire = state.retire;

endmodule : baseline_instruction_execute

// ===== hw/exec_pkg.sv
// Functional notes
// - Selector 0 writes accumulator, 1 writes slot
// - Increment slot, only zero flag updated
// - Decrement slot, status flags untouched
// - Zero decrement result discards prefetched instruction
// - Increment-skip: no flags, zero result skips
// - Branch loads nine-bit target, upper from status; here the nine-bit counter takes no page bits
// - Branch always takes two instruction cycles
// - OR literal into accumulator, zero flag updated
// - OR accumulator with slot, zero flag updated
// - Store accumulator into slot, flags untouched
// - Move slot, zero flag updated even to slot
// - Load literal into accumulator, flags untouched
// - Option load copies accumulator, flags untouched
// - Nine-bit program counter, 512 words of 12
package exec_pkg;

  // Widths
  localparam int PC_W = 9;
  localparam int INSTR_W = 12;
  localparam int DATA_W = 8;
  localparam int SLOT_W = 5;
  localparam int SLOTS = 32;

  // Instruction field positions
  localparam int DEST_BIT = 5;
  localparam int BRANCH_ABSOLUTE_OP_K_MSB = 8;
  localparam int LIT_MSB = 7;

  // Status layout: zero flag and the page bits, which the branch does not use
  localparam int ZERO_BIT = 2;
  localparam int PAGE_LSB = 5;
  localparam int PAGE_MSB = 6;

  // Reset values
  localparam logic [PC_W-1:0] PC_RESET = 9'h000;
  localparam logic [DATA_W-1:0] STATUS_RESET = 8'h18;
  localparam logic [DATA_W-1:0] OPTION_RESET = 8'hff;
  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
  localparam logic [INSTR_W-1:0] NOP_WORD = 12'h000;

  // Opcode patterns (compare after masking)
  localparam logic [INSTR_W-1:0] OPTION_WORD = 12'h002;
  localparam logic [INSTR_W-1:0] MASK_F = 12'hfe0;
  localparam logic [INSTR_W-1:0] MASK_DF = 12'hfc0;
  localparam logic [INSTR_W-1:0] MASK_K9 = 12'he00;
  localparam logic [INSTR_W-1:0] MASK_K8 = 12'hf00;
  localparam logic [INSTR_W-1:0] STORE_ACC_PAT = 12'h020;
  localparam logic [INSTR_W-1:0] OR_FILE_PAT = 12'h100;
  localparam logic [INSTR_W-1:0] MOVE_FILE_PAT = 12'h200;
  localparam logic [INSTR_W-1:0] INC_FILE_PAT = 12'h280;
  localparam logic [INSTR_W-1:0] DEC_SKIP_PAT = 12'h2c0;
  localparam logic [INSTR_W-1:0] INC_SKIP_PAT = 12'h3c0;
  localparam logic [INSTR_W-1:0] BRANCH_PAT = 12'ha00;
  localparam logic [INSTR_W-1:0] LOAD_LIT_PAT = 12'hc00;
  localparam logic [INSTR_W-1:0] OR_LIT_PAT = 12'hd00;

  // Two phases make one instruction cycle
  typedef enum logic {PH_FETCH, PH_EXEC} phase_t;

  // Architectural state seen from outside
  typedef struct packed {
    logic [DATA_W-1:0] acc;
    logic [DATA_W-1:0] status;
    logic [DATA_W-1:0] option;
  } core_view_t;

  // Whole state of the executing core
  typedef struct packed {
    phase_t phase;
    logic [PC_W-1:0] pc;
    logic [INSTR_W-1:0] ir;
    logic flush;
    logic retire;
    core_view_t view;
  } core_state_t;

endpackage : exec_pkg

// ===== hw/file_slots.sv
`timescale 1ns/1ps
// Data file register slots, one write and one registered read port
module file_slots
  import exec_pkg::*;
(
  // Clock
  input wire logic clock,
  // Write port
  input wire logic wr_en,
  input wire logic [SLOT_W-1:0] wr_addr,
  input wire logic [DATA_W-1:0] wr_data,
  // Read port, data one clock after address
  input wire logic [SLOT_W-1:0] rd_addr,
  output logic [DATA_W-1:0] rd_data
);

  // Storage, contents unknown after reset like real file memory
  logic [DATA_W-1:0] mem [SLOTS];

  // Write and registered read
  always_ff @(posedge clock)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule : file_slots

// ===== tb/baseline_instruction_execute_tb.sv
`timescale 1ns/1ps
// Runs short programs and checks the state they leave
module baseline_instruction_execute_tb import exec_pkg::*;;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic [PC_W-1:0] prog_addr;
  logic [INSTR_W-1:0] instr_data;
  core_view_t view;
  logic retire;
  int failures = 0;
  int n_compared = 0;
  always #4 clock = ~clock;
  baseline_instruction_execute dut (.clock(clock), .rstn(rstn), .prog_addr(prog_addr),
    .instr_data(instr_data), .view(view), .retire(retire));
  prog_rom rom (.prog_addr(prog_addr), .instr_data(instr_data));
  task automatic oops(input string m);
    failures++;
    $display("unexpected at %0t: %s", $time, m);
  endtask : oops
  // Byte results
  task automatic chk_byte(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    n_compared++;
    if (got !== exp) oops($sformatf("byte %h not %h", got, exp));
  endtask : chk_byte
  // Program addresses
  task automatic chk_addr(input logic [PC_W-1:0] got, input logic [PC_W-1:0] exp);
    n_compared++;
    if (got !== exp) oops($sformatf("address %h not %h", got, exp));
  endtask : chk_addr
  // Status as expected from the zero flag alone
  function automatic logic [DATA_W-1:0] st(input logic z);
    return {STATUS_RESET[7:3], z, STATUS_RESET[1:0]};
  endfunction : st
  // Fill memory, rest with no-operation, then reset for five clocks
  task automatic load(input logic [INSTR_W-1:0] w [$]);
    for (int i = 0; i < 512; i++)
      rom.mem[i] = (i < w.size()) ? w[i] : NOP_WORD;
    @(posedge clock);
    rstn <= 1'b0;
    repeat (5) @(posedge clock);
    rstn <= 1'b1;
  endtask : load
  // Wait for n instruction cycles, bounded
  task automatic run(input int n);
    int k;
    k = 0;
    repeat (4 * n + 4)
    begin
      @(posedge clock);
      #1;
      if (retire === 1'b1) k++;
      if (k == n) break;
    end
    if (k != n) oops("missing retire");
  endtask : run
  // Literal, store, option, move and OR forms
  task automatic t_move();
    load('{12'hc00, 12'hd00, 12'hc5a, 12'h023, 12'h002, 12'hc00, 12'h203,
      12'hc81, 12'h123, 12'h203, 12'hc00, 12'h024, 12'hd01, 12'h224});
    run(3);
    chk_byte(view.status, st(1'b1));
    run(7);
    chk_byte(view.acc, 8'h5a | 8'h81);
    chk_byte(view.status, st(1'b0));
    chk_byte(view.option, 8'h5a);
    run(4);
    chk_byte(view.acc, 8'h01);
    chk_byte(view.status, st(1'b1));
    $display("move test done");
  endtask : t_move
  // Skip forms, skipped words would load ee
  task automatic t_skip();
    load('{12'hc01, 12'h027, 12'hd00, 12'h2e7, 12'hcee, 12'h3c7, 12'hcff, 12'h028, 12'h3e8, 12'hcee,
      12'h207, 12'h288});
    run(5);
    chk_byte(view.acc, 8'h01);
    chk_byte(view.status, st(1'b0));
    run(5);
    chk_byte(view.acc, 8'hff);
    chk_byte(view.status, st(1'b0));
    run(1);
    chk_byte(view.acc, 8'h00);
    run(1);
    chk_byte(view.acc, 8'h01);
    chk_byte(view.status, st(1'b0));
    $display("skip test done");
  endtask : t_skip
  // Branch near the top of the space
  task automatic t_branch();
    load('{12'hbf0, 12'hcee});
    rom.mem[9'h1f0] = 12'hc33;
    rom.mem[9'h1f1] = 12'hcee;
    run(1);
    chk_addr(prog_addr, 9'h1f0);
    run(1);
    chk_byte(view.acc, 8'h00);
    chk_addr(prog_addr, 9'h1f0);
    run(1);
    chk_byte(view.acc, 8'h33);
    chk_addr(prog_addr, 9'h1f1);
    $display("branch test done");
  endtask : t_branch
  // Counts, verdict, end of run
  task automatic print_verdict();
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  initial
  begin
    t_move();
    t_skip();
    t_branch();
    print_verdict();
  end
  // Hang guard, about eight times the expected run
  initial
  begin
    #5000;
    oops("watchdog");
    print_verdict();
  end
endmodule : baseline_instruction_execute_tb

// ===== tb/exec_props.sv
`timescale 1ns/1ps
// Port-level checks of the two-clock instruction cycle
module exec_props
  import exec_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Watched ports
  input wire logic [PC_W-1:0] prog_addr,
  input wire logic [INSTR_W-1:0] instr_data,
  input wire core_view_t view,
  input wire logic retire
);
  logic fe; // Next edge is a fetch
  logic hot; // Next fetch may be thrown away
  // Skips count as hot whatever the slot holds: loses a little reach, and a branch or skip just after an untaken skip is not tracked
  wire is_br = (instr_data & MASK_K9) == BRANCH_PAT;
  wire is_sk = (instr_data & MASK_DF) == DEC_SKIP_PAT || (instr_data & MASK_DF) == INC_SKIP_PAT;
  wire is_ll = (instr_data & MASK_K8) == LOAD_LIT_PAT;
  wire is_ol = (instr_data & MASK_K8) == OR_LIT_PAT;
  // Sampled reset keeps the release edge, which is no fetch, out of every antecedent
  wire ok = fe && !hot && rstn; // Fetched word will really run, unless a branch or skip just after an untaken skip flushed it
  // Phase tracker, first edge after reset is a fetch
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      fe <= 1'b1;
      hot <= 1'b0;
    end
    else
    begin
      fe <= !fe;
      if (fe)
        hot <= !hot && (is_br || is_sk);
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  AST_EXEC_NO_RETIRE: assert property (!fe |-> !retire) else $error("retire off cadence");
  AST_RETIRE_GAP: assert property (retire |-> ##2 retire) else $error("retire gap wrong");
  // Flushed fetches hold the counter, so only fetches marked ok are checked; one flushed behind an untaken skip can slip in
  AST_PC_STEP: assert property (ok |-> ##1 prog_addr == $past(prog_addr) + 9'h001)
    else $error("fetch did not advance address");
  AST_LOAD_LIT: assert property (ok && is_ll |-> ##2 view.acc == $past(instr_data[LIT_MSB:0], 2)
    && $stable(view.status)) else $error("literal load wrong");
  AST_OR_LIT: assert property (ok && is_ol |-> ##2 view.acc == ($past(view.acc) | $past(instr_data[7:0], 2))
    && view.status[ZERO_BIT] == (view.acc == 8'h00)) else $error("literal or wrong");
  AST_OPTION: assert property (ok && instr_data == OPTION_WORD |-> ##2 view.option == $past(view.acc)
    && $stable(view.status)) else $error("option load wrong");
  AST_BRANCH: assert property (ok && is_br |-> ##2 prog_addr == $past(instr_data[BRANCH_ABSOLUTE_OP_K_MSB:0], 2)
    && $stable(view)) else $error("branch target wrong");
  AST_BRANCH_HOLD: assert property (ok && is_br |-> ##4 prog_addr == $past(instr_data[BRANCH_ABSOLUTE_OP_K_MSB:0], 4)
    && view == $past(view, 3)) else $error("branch did not resume at its target");
  AST_NOP: assert property (ok && instr_data == NOP_WORD |-> ##2 $stable(view))
    else $error("no-operation changed state");
  AST_STATUS_FIXED: assert property ({view.status[7:3], view.status[1:0]} ==
    {STATUS_RESET[7:3], STATUS_RESET[1:0]}) else $error("status bit other than zero moved");
  // Main scenarios reached
  cover property (ok && is_br);
  cover property (ok && is_sk);
  cover property (ok && is_ol);
endmodule : exec_props

bind baseline_instruction_execute exec_props u_props (.clock(clock), .rstn(rstn), .prog_addr(prog_addr),
  .instr_data(instr_data), .view(view), .retire(retire));

// ===== tb/prog_rom.sv
`timescale 1ns/1ps
// Program memory, word valid in the same clock as its address
module prog_rom
  import exec_pkg::*;
(
  // From the core
  input wire logic [PC_W-1:0] prog_addr,
  // Back to the core
  output logic [INSTR_W-1:0] instr_data
);
  logic [INSTR_W-1:0] mem [512];
  // Whole nine-bit space decoded, no wrap
  assign instr_data = mem[prog_addr];
endmodule : prog_rom
